// File: pkg/rdps_map.svh
`ifndef RDPS_MAP_SVH
`define RDPS_MAP_SVH
// ==========================================================
// register offsets
`define RDPS_OFF_CTRL0     8'h20
`define RDPS_OFF_LOWTGT0   8'h28
`define RDPS_OFF_DWELL     8'h30
`define RDPS_OFF_MASK_A    8'h40
`define RDPS_OFF_MASK_B    8'h41
`define RDPS_OFF_GOOD_A    8'h42
`define RDPS_OFF_GOOD_B    8'h43
`define RDPS_OFF_FAULT_A   8'h44
`define RDPS_OFF_FAULT_B   8'h45
`define RDPS_OFF_MISC      8'hE9
// ==========================================================
// field positions
`define RDPS_CTRL_SWEN     0
`define RDPS_CTRL_REGSEL   1
`define RDPS_MISC_IGNPIN   7
`define RDPS_MISC_SWEN     6
// ==========================================================
// reset values
`define RDPS_CTRL_RST      8'h00
`define RDPS_LOWTGT_RST    6'h00
`define RDPS_DWELL_RST     2'h1
// ==========================================================
// timing, in microseconds unless noted
`define RDPS_CLK_NS        8
`define RDPS_TICK_NS       1000
`define RDPS_TICK_CYC      (`RDPS_TICK_NS / `RDPS_CLK_NS)
`define RDPS_STEP_MV       25
`define RDPS_DWELL0_US     3
`define RDPS_DWELL1_US     5
`define RDPS_DWELL2_US     6
`define RDPS_DWELL3_US     7
`define RDPS_PWM_HOLD_US   10
`define RDPS_PG_HOLD_US    100
`define RDPS_SUSP_MASK_US  100
`define RDPS_DEGLITCH_US   30
`define RDPS_DCM_CYCLES    16
`define RDPS_BLANK_US      10000
`endif

// File: pkg/rdps_pkg.sv
package rdps_pkg;
	localparam int NREG  = 5;
	localparam int NRAIL = 6;
	// inputs that arrive from outside the clock domain
	typedef struct packed {
		logic [NREG-1:0]  railEnablePin;
		logic             terminationLdoEnablePin;
		logic             standby_n;
		logic [NRAIL-1:0] inRange;
		logic [NREG-1:0]  dcmDetect;
		logic             swCycle;
	} rdps_pins_s;
	// rail_control_register layout
	typedef struct packed {
		logic [5:0] voltCode;
		logic       regSelect;
		logic       swEnable;
	} rdps_ctrl_s;
	typedef enum logic {MODE_DCM, MODE_CCM} rdps_mode_e;
endpackage : rdps_pkg

// File: verilog/rdps_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
`include "rdps_map.svh"
// Summary of operation
// - reference moves one 25 mV code per step
// - each step dwells 5 us by default
// - dwell selectable 3, 5, 6 or 7 us
// - force PWM until 10 us after ramp
// - mask power-good until 100 us after ramp
// - CCM to DCM after 16-cycle deglitch
// - DCM to CCM immediately
// - automatic power-save mode after reset
// - enable by pin (default) or register
// - misc bit7 ignores pin, bit6 enables LDO
// - termination LDO only with all unmasked regulator goods high
// - scaling accepted any time after power-up
// - readable in-window status per enabled rail
// - unmasked fault shuts whole system down
// - fault source kept across shutdown
// - mask bits exclude rail, block shutdown
// - ignore rail faults 10 ms after enable
// - mask comparators 100 us after system good
// - out-of-window input sets rail fault flag
// - termination pin scales rail 3, standby others
// - power-good deglitch 30 us both edges
module rdps_supervisor
	import rdps_pkg::*;
#(
	parameter int BLANK_US = `RDPS_BLANK_US
)(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire rdps_pins_s            pinsIn,
	input  wire logic [7:0]            regAddr,
	input  wire logic                  regWrEn,
	input  wire logic                  regRdEn,
	input  wire logic [7:0]            regWrData,
	output logic      [7:0]            regRdData,
	output logic      [NRAIL-1:0]      railOn,
	output logic      [NREG-1:0]       pwmMode,
	output logic      [NREG-1:0][5:0]  refCode,
	output logic      [NRAIL-1:0]      railGood,
	output logic                       combinedSystemGood,
	output logic                       shutdown
);
	// ==========================================================
	// synchronisers and timebase
	rdps_pins_s       syncA;
	rdps_pins_s       syncB;
	logic             swCycleDly;
	logic [6:0]       tickCnt;
	logic             usTick;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			syncA      <= '0;
			syncB      <= '0;
			swCycleDly <= 1'b0;
		end
		else
		begin
			syncA      <= pinsIn;
			syncB      <= syncA;
			swCycleDly <= syncB.swCycle;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tickCnt <= '0;
			usTick  <= 1'b0;
		end
		else
		begin
			usTick  <= (tickCnt == 7'(`RDPS_TICK_CYC - 1));
			tickCnt <= (tickCnt == 7'(`RDPS_TICK_CYC - 1)) ? '0 : tickCnt + 7'd1;
		end
	end

	wire logic swEdge = syncB.swCycle & ~swCycleDly;

	// ==========================================================
	// register file
	rdps_ctrl_s       ctrl_reg [NREG];
	logic [5:0]       lowTgt_reg [NREG];
	logic [1:0]       dwellSel_reg;
	logic [NREG-1:0]  maskA_reg;
	logic             maskB_reg;
	logic [NRAIL-1:0] fault_reg;
	logic [1:0]       misc_reg;
	logic [NRAIL-1:0] faultSet;
	logic [NRAIL-1:0] faultClr;
	logic [NRAIL-1:0] mask;

	assign mask = {maskB_reg, maskA_reg};

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < NREG; i++)
			begin
				ctrl_reg[i]   <= `RDPS_CTRL_RST;
				lowTgt_reg[i] <= `RDPS_LOWTGT_RST;
			end
			dwellSel_reg <= `RDPS_DWELL_RST;
			maskA_reg    <= '0;
			maskB_reg    <= 1'b0;
			misc_reg     <= '0;
		end
		else if (regWrEn)
		begin
			for (int i = 0; i < NREG; i++)
			begin
				if (regAddr == `RDPS_OFF_CTRL0 + 8'(i))
					ctrl_reg[i] <= regWrData;
				if (regAddr == `RDPS_OFF_LOWTGT0 + 8'(i))
					lowTgt_reg[i] <= regWrData[5:0];
			end
			if (regAddr == `RDPS_OFF_DWELL)
				dwellSel_reg <= regWrData[1:0];
			if (regAddr == `RDPS_OFF_MASK_A)
				maskA_reg <= regWrData[NREG-1:0];
			if (regAddr == `RDPS_OFF_MASK_B)
				maskB_reg <= regWrData[0];
			if (regAddr == `RDPS_OFF_MISC)
				misc_reg <= {regWrData[`RDPS_MISC_IGNPIN], regWrData[`RDPS_MISC_SWEN]};
		end
	end

	// write-one-to-clear on fault source registers
	always_comb
	begin
		faultClr = '0;
		if (regWrEn && regAddr == `RDPS_OFF_FAULT_A)
			faultClr[NREG-1:0] = regWrData[NREG-1:0];
		if (regWrEn && regAddr == `RDPS_OFF_FAULT_B)
			faultClr[NRAIL-1] = regWrData[0];
	end

	// sticky fault source, set wins over clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			fault_reg <= '0;
		else
			fault_reg <= (fault_reg & ~faultClr) | faultSet;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			regRdData <= '0;
		else if (regRdEn)
		begin
			regRdData <= '0;
			for (int i = 0; i < NREG; i++)
			begin
				if (regAddr == `RDPS_OFF_CTRL0 + 8'(i))
					regRdData <= ctrl_reg[i];
				if (regAddr == `RDPS_OFF_LOWTGT0 + 8'(i))
					regRdData <= {2'h0, lowTgt_reg[i]};
			end
			unique case (regAddr)
				`RDPS_OFF_DWELL:  regRdData <= {6'h00, dwellSel_reg};
				`RDPS_OFF_MASK_A: regRdData <= {3'h0, maskA_reg};
				`RDPS_OFF_MASK_B: regRdData <= {7'h00, maskB_reg};
				`RDPS_OFF_GOOD_A: regRdData <= {3'h0, railGood[NREG-1:0]};
				`RDPS_OFF_GOOD_B: regRdData <= {7'h00, railGood[NRAIL-1]};
				`RDPS_OFF_FAULT_A: regRdData <= {3'h0, fault_reg[NREG-1:0]};
				`RDPS_OFF_FAULT_B: regRdData <= {7'h00, fault_reg[NRAIL-1]};
				`RDPS_OFF_MISC:   regRdData <= {misc_reg, 6'h00};
				default:          ;
			endcase
		end
	end

	// ==========================================================
	// enables, tree and shutdown
	logic [NRAIL-1:0] enReq;
	logic [NRAIL-1:0] railOnDly;
	logic [6:0]       suspCnt;
	logic             combinedDly;
	logic [NRAIL-1:0] dvsMask;
	logic [NRAIL-1:0] blankActive;
	logic             termPinReq;
	logic [3:0]       dwellUs;

	assign termPinReq = misc_reg[0] | (~misc_reg[1] & syncB.terminationLdoEnablePin);

	always_comb
	begin
		for (int i = 0; i < NREG; i++)
		begin
			enReq[i] = ctrl_reg[i].regSelect ? ctrl_reg[i].swEnable : syncB.railEnablePin[i];
		end
		enReq[NRAIL-1] = termPinReq & combinedSystemGood;
	end

	always_comb
	begin
		unique case (dwellSel_reg)
			2'h0: dwellUs = 4'(`RDPS_DWELL0_US);
			2'h1: dwellUs = 4'(`RDPS_DWELL1_US);
			2'h2: dwellUs = 4'(`RDPS_DWELL2_US);
			2'h3: dwellUs = 4'(`RDPS_DWELL3_US);
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			railOn             <= '0;
			railOnDly          <= '0;
			combinedSystemGood <= 1'b0;
			combinedDly        <= 1'b0;
			shutdown           <= 1'b0;
		end
		else
		begin
			railOn             <= shutdown ? '0 : enReq;
			railOnDly          <= railOn;
			combinedSystemGood <= &(railGood[NREG-1:0] | maskA_reg);
			combinedDly        <= combinedSystemGood;
			if (|(faultSet & ~mask))
				shutdown <= 1'b1;
			else if (fault_reg == '0)
				shutdown <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			suspCnt <= '0;
		else if (combinedSystemGood && !combinedDly)
			suspCnt <= 7'(`RDPS_SUSP_MASK_US);
		else if (usTick && suspCnt != '0)
			suspCnt <= suspCnt - 7'd1;
	end

	// ==========================================================
	// per-rail blanking, deglitch and fault detection
	genvar r;
	generate
		for (r = 0; r < NRAIL; r++)
		begin : g_rail
			logic [13:0] blankCnt;
			logic [4:0]  dgCnt;

			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					blankCnt <= '0;
				else if (railOn[r] && !railOnDly[r])
					blankCnt <= 14'(BLANK_US);
				else if (usTick && blankCnt != '0)
					blankCnt <= blankCnt - 14'd1;
			end
			assign blankActive[r] = (blankCnt != '0);

			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					railGood[r] <= 1'b0;
					dgCnt       <= '0;
				end
				else if (!railOn[r])
				begin
					railGood[r] <= 1'b0;
					dgCnt       <= '0;
				end
				else if (syncB.inRange[r] == railGood[r])
					dgCnt <= '0;
				else if (usTick)
				begin
					if (dgCnt == 5'(`RDPS_DEGLITCH_US - 1))
					begin
						railGood[r] <= syncB.inRange[r];
						dgCnt       <= '0;
					end
					else
						dgCnt <= dgCnt + 5'd1;
				end
			end

			assign faultSet[r] = railOn[r] & railOnDly[r] & ~blankActive[r] & ~dvsMask[r]
				& (suspCnt == '0) & ~railGood[r] & ~syncB.inRange[r];
		end
	endgenerate

	assign dvsMask[NRAIL-1] = 1'b0;

	// ==========================================================
	// per-regulator scaling and conduction mode
	genvar v;
	generate
		for (v = 0; v < NREG; v++)
		begin : g_reg
			logic [5:0]  target;
			logic [3:0]  dwellCnt;
			logic [6:0]  postCnt;
			logic [4:0]  dcmCnt;
			logic        ramping;
			logic        forcePwm;
			rdps_mode_e  mode;

			if (v == 3)
			begin : g_term
				assign target = !syncB.terminationLdoEnablePin ? lowTgt_reg[v] : ctrl_reg[v].voltCode;
			end
			else
			begin : g_stby
				assign target = !syncB.standby_n ? lowTgt_reg[v] : ctrl_reg[v].voltCode;
			end

			assign ramping = (refCode[v] != target);

			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					refCode[v] <= '0;
					dwellCnt   <= '0;
				end
				else if (!railOn[v] || blankActive[v])
				begin
					refCode[v] <= ctrl_reg[v].voltCode;
					dwellCnt   <= '0;
				end
				else if (!ramping)
					dwellCnt <= '0;
				else if (usTick)
				begin
					if (dwellCnt >= dwellUs - 4'd1)
					begin
						dwellCnt   <= '0;
						refCode[v] <= (target > refCode[v]) ? refCode[v] + 6'd1 : refCode[v] - 6'd1;
					end
					else
						dwellCnt <= dwellCnt + 4'd1;
				end
			end

			// time since ramp end, saturates
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					postCnt <= 7'(`RDPS_PG_HOLD_US);
				else if (ramping && railOn[v] && !blankActive[v])
					postCnt <= '0;
				else if (usTick && postCnt != 7'(`RDPS_PG_HOLD_US))
					postCnt <= postCnt + 7'd1;
			end

			assign forcePwm = (ramping && railOn[v] && !blankActive[v]) || postCnt < 7'(`RDPS_PWM_HOLD_US);
			assign dvsMask[v] = (ramping && railOn[v] && !blankActive[v])
				|| postCnt < 7'(`RDPS_PG_HOLD_US);

			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					mode   <= MODE_CCM;
					dcmCnt <= '0;
				end
				else if (forcePwm || !syncB.dcmDetect[v])
				begin
					mode   <= MODE_CCM;
					dcmCnt <= '0;
				end
				else if (mode == MODE_CCM && swEdge)
				begin
					if (dcmCnt == 5'(`RDPS_DCM_CYCLES - 1))
						mode <= MODE_DCM;
					dcmCnt <= dcmCnt + 5'd1;
				end
			end

			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					pwmMode[v] <= 1'b1;
				else
					pwmMode[v] <= (mode == MODE_CCM);
			end
		end
	endgenerate
endmodule : rdps_supervisor
`default_nettype wire

// File: verif/rdps_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// supervisor port checker
module rdps_checker
	import rdps_pkg::*;
#(
	parameter int BLANK_US = 10000
)(
	input wire logic                 clk,
	input wire logic                 rst_n,
	input wire rdps_pins_s           pinsIn,
	input wire logic [7:0]           regAddr,
	input wire logic                 regWrEn,
	input wire logic                 regRdEn,
	input wire logic [7:0]           regWrData,
	input wire logic [7:0]           regRdData,
	input wire logic [NRAIL-1:0]     railOn,
	input wire logic [NREG-1:0]      pwmMode,
	input wire logic [NREG-1:0][5:0] refCode,
	input wire logic [NRAIL-1:0]     railGood,
	input wire logic                 combinedSystemGood,
	input wire logic                 shutdown
);
	// raw count, so sync stages give slack
	localparam int GOOD_MIN = 3600;
	localparam int STEP_MIN = 300;
	logic [15:0] inCnt_reg;
	logic [15:0] gapCnt_reg;
	logic [5:0]  prevCode_reg;
	logic        stepSeen;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ====
	// helper counters
	// in-window run
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			inCnt_reg <= 16'h0000;
		else if (!pinsIn.inRange[0])
			inCnt_reg <= 16'h0000;
		else if (inCnt_reg != 16'hFFFF)
			inCnt_reg <= inCnt_reg + 16'h0001;
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			gapCnt_reg <= 16'h0000;
		else if (refCode[0] != prevCode_reg)
			gapCnt_reg <= 16'h0000;
		else if (gapCnt_reg != 16'hFFFF)
			gapCnt_reg <= gapCnt_reg + 16'h0001;
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			prevCode_reg <= 6'h00;
		else
			prevCode_reg <= refCode[0];
	assign stepSeen = (refCode[0] != prevCode_reg) && !pinsIn.standby_n;
	// ====
	// properties
	ldo_needs_good_a: assert property ((!combinedSystemGood) [*3] |-> !railOn[5])
		else $error("termination rail on without system good");
	off_rail_a: assert property ((!railOn[0]) [*3] |-> !railGood[0])
		else $error("good shown on disabled rail");
	shut_drops_a: assert property (shutdown [*2] |-> railOn == 6'h00)
		else $error("rails kept on in shutdown");
	ccm_prompt_a: assert property ((!pinsIn.dcmDetect[0]) [*5] |-> pwmMode[0])
		else $error("late return to continuous mode");
	dcm_wait_a: assert property ($fell(pwmMode[0]) |-> $past(pinsIn.dcmDetect[0], 8))
		else $error("discontinuous mode entered early");
	good_settle_a: assert property ($rose(railGood[0]) |-> inCnt_reg >= GOOD_MIN)
		else $error("power good rose before deglitch");
	step_dwell_a: assert property (stepSeen |-> gapCnt_reg >= STEP_MIN)
		else $error("reference step too soon");
	step_size_a: assert property (stepSeen |-> prevCode_reg - refCode[0] == 6'h01)
		else $error("reference step not one code");
	cover property ($rose(shutdown));
	cover property ($fell(pwmMode[0]));
	cover property (stepSeen);
endmodule : rdps_checker
bind rdps_supervisor rdps_checker #(.BLANK_US(BLANK_US)) chk_u (
	.clk(clk), .rst_n(rst_n), .pinsIn(pinsIn), .regAddr(regAddr),
	.regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
	.regRdData(regRdData), .railOn(railOn), .pwmMode(pwmMode),
	.refCode(refCode), .railGood(railGood),
	.combinedSystemGood(combinedSystemGood), .shutdown(shutdown)
);
`default_nettype wire

// File: verif/rdps_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// controller model
module rdps_ctl_model
	import rdps_pkg::*;
(
	input  wire logic       clk,
	output var rdps_pins_s  pins,
	output logic [7:0]      regAddr,
	output logic            regWrEn,
	output logic            regRdEn,
	output logic [7:0]      regWrData,
	input  wire logic [7:0] regRdData
);
	logic [2:0] cyc_reg = 3'h0;
	initial
	begin
		pins = '0;
		pins.standby_n = 1'b1;
		pins.inRange = 6'h3F;
		regAddr = 8'h00;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regWrData = 8'h00;
	end
	// ====
	// switching cycle, four clocks a level
	always @(posedge clk)
	begin
		cyc_reg <= cyc_reg + 3'h1;
		pins.swCycle <= cyc_reg[2];
	end
	// ====
	// register port, address held through the strobe edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		@(posedge clk);
		d = regRdData;
	endtask : rd
endmodule : rdps_ctl_model
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// supervisor testbench
module tb_top
	import rdps_pkg::*;
;
	logic                 clk = 1'b0;
	logic                 rst_n = 1'b0;
	rdps_pins_s           pins;
	logic [7:0]           regAddr;
	logic                 regWrEn;
	logic                 regRdEn;
	logic [7:0]           regWrData;
	logic [7:0]           regRdData;
	logic [NRAIL-1:0]     railOn;
	logic [NREG-1:0]      pwmMode;
	logic [NREG-1:0][5:0] refCode;
	logic [NRAIL-1:0]     railGood;
	logic                 combinedSystemGood;
	logic                 shutdown;
	int                   miscompares = 0;
	int                   n_checks = 0;
	int                   cycles = 0;
	int                   n;
	rdps_ctl_model ctl_u (
		.clk(clk), .pins(pins), .regAddr(regAddr), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData)
	);
	// short blanking keeps the run brief
	rdps_supervisor #(.BLANK_US(20)) dut_u (
		.clk(clk), .rst_n(rst_n), .pinsIn(pins), .regAddr(regAddr),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
		.regRdData(regRdData), .railOn(railOn), .pwmMode(pwmMode),
		.refCode(refCode), .railGood(railGood),
		.combinedSystemGood(combinedSystemGood), .shutdown(shutdown)
	);
	initial
	begin
		forever #4 clk = ~clk;
	end
	// ====
	// checking and closing
	task automatic end_of_test;
		if (miscompares == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic chkCnt(input int g, input int lo, input int hi);
		n_checks++;
		if (g < lo || g > hi)
		begin
			miscompares++;
			$display("CHECK FAILED %0t count %0d", $time, g);
		end
	endtask : chkCnt
	task automatic waitCode(input logic [5:0] c);
		n = 0;
		while (refCode[0] !== c && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
	endtask : waitCode
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			miscompares++;
			$display("CHECK FAILED %0t timeout", $time);
			end_of_test();
		end
	end
	// ====
	// scenarios
	task automatic tRegs;
		logic [7:0] v;
		ctl_u.rd(8'h30, v);
		chk(v, 8'h01);
		ctl_u.rd(8'h10, v);
		chk(v, 8'h00);
		chk(8'(pwmMode), 8'h1F);
		ctl_u.wr(8'h42, 8'hFF);
		ctl_u.rd(8'h42, v);
		chk(v, 8'h00);
	endtask : tRegs
	task automatic tEnable;
		logic [7:0] v;
		ctl_u.wr(8'h20, 8'h10);
		ctl_u.wr(8'h28, 8'h01);
		ctl_u.pins.railEnablePin <= 5'h03;
		repeat (5) @(posedge clk);
		chk(8'(railOn), 8'h03);
		chk(8'(refCode[0]), 8'h04);
		ctl_u.wr(8'h22, 8'h03);
		repeat (3) @(posedge clk);
		chk(8'(railOn), 8'h07);
		repeat (4000) @(posedge clk);
		ctl_u.rd(8'h42, v);
		chk(v, 8'h07);
	endtask : tEnable
	task automatic tMask;
		logic [7:0] v;
		ctl_u.wr(8'h40, 8'h02);
		ctl_u.pins.inRange[1] <= 1'b0;
		repeat (4500) @(posedge clk);
		chk(8'(shutdown), 8'h00);
		ctl_u.rd(8'h44, v);
		chk(v, 8'h02);
	endtask : tMask
	task automatic tLdo;
		ctl_u.wr(8'h40, 8'h1F);
		ctl_u.wr(8'hE9, 8'h40);
		repeat (4) @(posedge clk);
		chk(8'(combinedSystemGood), 8'h01);
		chk(8'(railOn[5]), 8'h01);
		ctl_u.pins.terminationLdoEnablePin <= 1'b1;
		ctl_u.wr(8'hE9, 8'h80);
		repeat (4) @(posedge clk);
		chk(8'(railOn[5]), 8'h00);
		ctl_u.wr(8'h40, 8'h02);
		ctl_u.wr(8'hE9, 8'h40);
		repeat (4) @(posedge clk);
		chk(8'(railOn[5]), 8'h00);
		ctl_u.wr(8'hE9, 8'h00);
		ctl_u.pins.terminationLdoEnablePin <= 1'b0;
	endtask : tLdo
	task automatic tDvs;
		logic [7:0] v;
		ctl_u.pins.dcmDetect[0] <= 1'b1;
		ctl_u.pins.standby_n <= 1'b0;
		waitCode(6'h01);
		chkCnt(n, 1700, 1900);
		chk(8'(pwmMode[0]), 8'h01);
		n = 0;
		while (pwmMode[0] === 1'b1 && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		chkCnt(n, 1360, 1400);
		ctl_u.pins.dcmDetect[0] <= 1'b0;
		repeat (5) @(posedge clk);
		chk(8'(pwmMode[0]), 8'h01);
		ctl_u.wr(8'h30, 8'h00);
		ctl_u.pins.standby_n <= 1'b1;
		waitCode(6'h04);
		chkCnt(n, 1000, 1150);
		ctl_u.pins.inRange[0] <= 1'b0;
		n = 0;
		while (shutdown !== 1'b1 && n < 14000)
		begin
			@(posedge clk);
			n++;
		end
		chkCnt(n, 12300, 12700);
		repeat (3) @(posedge clk);
		chk(8'(railOn), 8'h00);
		ctl_u.rd(8'h44, v);
		chk(v, 8'h03);
		ctl_u.pins.inRange <= 6'h3F;
		ctl_u.wr(8'h44, 8'h03);
		repeat (4) @(posedge clk);
		chk(8'(shutdown), 8'h00);
		ctl_u.pins.inRange[0] <= 1'b0;
		n = 0;
		while (shutdown !== 1'b1 && n < 4000)
		begin
			@(posedge clk);
			n++;
		end
		chkCnt(n, 2300, 2600);
	endtask : tDvs
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		tRegs();
		tEnable();
		tMask();
		tLdo();
		tDvs();
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
